/* File: verilog/bsrba_params.svh */
// Purpose: offsets, fields and constants of the bit/shift/bcd datapath
// Assumes: 32-bit axi4-lite data, byte addresses
// Notes: definitions only
`ifndef BSRBA_PARAMS_SVH
`define BSRBA_PARAMS_SVH
`define BSRBA_ADDR_W 8
`define BSRBA_OFS_CTRL 8'h00
`define BSRBA_OFS_DEST 8'h04
`define BSRBA_OFS_SRC 8'h08
`define BSRBA_OFS_COUNT 8'h0c
`define BSRBA_OFS_FLAGS 8'h10
`define BSRBA_OFS_STATUS 8'h14
`define BSRBA_CTRL_GO 31
`define BSRBA_CTRL_OP 4:0
`define BSRBA_CTRL_SIZE 9:8
`define BSRBA_CTRL_COND 15:12
`define BSRBA_COUNT_F 4:0
`define BSRBA_F_CARRY 0
`define BSRBA_F_PARITY 1
`define BSRBA_F_AUX 2
`define BSRBA_F_ZERO 3
`define BSRBA_F_SIGN 4
`define BSRBA_F_OVFL 5
`define BSRBA_LOW_F 7:0
`define BSRBA_HIGH_F 15:8
`define BSRBA_ST_BUSY 0
`define BSRBA_ST_SRCZ 1
`define BSRBA_MASK_B 32'h0000_00ff
`define BSRBA_MASK_W 32'h0000_ffff
`define BSRBA_MASK_D 32'hffff_ffff
`define BSRBA_TOP_B 5'h07
`define BSRBA_TOP_W 5'h0f
`define BSRBA_TOP_D 5'h1f
`define BSRBA_NIB_MASK 8'h0f
`define BSRBA_NIB_MAX 8'h09
`define BSRBA_PACK_MAX 8'h99
`define BSRBA_ADJ_LO 8'h06
`define BSRBA_ADJ_HI 8'h60
`define BSRBA_DEC_BASE 8'h0a
`define BSRBA_RESP_OKAY 2'b00
`define BSRBA_RESP_SLVERR 2'b10
`endif

/* File: verilog/bsrba_pkg.sv */
// Purpose: types of the bit/shift/bcd datapath
// Assumes: bsrba_params.svh for numbers
// Notes: one-hot state codes
package bsrba_pkg;
    typedef enum logic [4:0] {
        OP_AND = 5'h00, OP_OR = 5'h01, OP_XOR = 5'h02, OP_NOT = 5'h03,
        OP_SLL = 5'h04, OP_SRL = 5'h05, OP_SRA = 5'h06, OP_DSL = 5'h07,
        OP_DSR = 5'h08, OP_RTL = 5'h09, OP_RTR = 5'h0a, OP_RTCL = 5'h0b,
        OP_RTCR = 5'h0c, OP_BTST = 5'h0d, OP_BSET = 5'h0e, OP_BCLR = 5'h0f,
        OP_BINV = 5'h10, OP_SCUP = 5'h11, OP_SCDN = 5'h12, OP_SETC = 5'h13,
        OP_PADD = 5'h14, OP_PSUB = 5'h15, OP_UADD = 5'h16, OP_USUB = 5'h17,
        OP_UMUL = 5'h18, OP_UDIV = 5'h19
    } bsrba_op_type;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_DWORD = 2'h2
    } bsrba_size_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01, ST_EXEC = 2'b10
    } bsrba_state_type;
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } bsrba_axi_req_type;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bsrba_axi_rsp_type;
    typedef struct packed {
        bsrba_state_type state;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl;
        logic [31:0] dest;
        logic [31:0] src;
        logic [4:0] count;
        logic [7:0] flags;
        logic src_zero;
    } bsrba_state_rec_type;
endpackage

/* File: verilog/bsrba_core.sv */
// Purpose: bcd adjust, logic, shift, rotate, bit and set-on-condition datapath
// Assumes: axi4-lite slave, one aclk, synchronous active-low reset
// Notes: an operation runs one cycle after the go write
// Operation
// - packed add adjust fixes low byte to two bcd digits, carry on decimal carry
// - packed sub adjust fixes low byte to two bcd digits, carry on borrow
// - unpacked add adjust keeps low nibble, carry sets and bumps high byte
// - unpacked sub adjust keeps low nibble, borrow sets carry, high byte down
// - unpacked mul adjust splits low byte into tens (high) and units (low)
// - unpacked div prep folds high tens and low units into low byte
// - and, or, xor on two operands and not on one
// - logical left shift shifts by 1..31, zero fill, carry gets last out
// - logical right shift zero fills, carry gets last bit out
// - arithmetic right shift refills with sign, carry gets last out
// - double left shift fills from source, source kept, carry last out
// - rotates take 0..31 and lose no bit; left goes toward msb
// - left rotate through carry treats carry as bit above msb
// - right rotate through carry uses carry between lsb and msb
// - every rotate leaves carry equal to last bit rotated out
// - bit test copies bit to carry, then set, clear, invert or keep
// - scan up from bit 0, scan down from msb, write first set index
// - set byte writes 1 or 0 from condition over five flags
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`include "bsrba_params.svh"
`timescale 1ns/100ps
`default_nettype none
module bsrba_core
    import bsrba_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire bsrba_axi_req_type axi_req,
    output bsrba_axi_rsp_type axi_rsp
);

////////////////////////////////////////////////////////////////////////////////
    bsrba_state_rec_type s_r;
    bsrba_state_rec_type s_nxt;

    function automatic logic [31:0] width_mask(input bsrba_size_type sz);
        case (sz)
            SZ_BYTE: width_mask = `BSRBA_MASK_B;
            SZ_WORD: width_mask = `BSRBA_MASK_W;
            default: width_mask = `BSRBA_MASK_D;
        endcase
    endfunction

    function automatic logic [4:0] top_bit(input bsrba_size_type sz);
        case (sz)
            SZ_BYTE: top_bit = `BSRBA_TOP_B;
            SZ_WORD: top_bit = `BSRBA_TOP_W;
            default: top_bit = `BSRBA_TOP_D;
        endcase
    endfunction

    // per-byte strobe merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = old;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                merge[k*8 +: 8] = nw[k*8 +: 8];
            end
        end
    endfunction

    function automatic logic cond_met(input logic [3:0] cc, input logic [7:0] f);
        logic base;
        base = 1'b0;
        case (cc[3:1])
            3'h0: base = f[`BSRBA_F_OVFL];
            3'h1: base = f[`BSRBA_F_CARRY];
            3'h2: base = f[`BSRBA_F_ZERO];
            3'h3: base = f[`BSRBA_F_CARRY] | f[`BSRBA_F_ZERO];
            3'h4: base = f[`BSRBA_F_SIGN];
            3'h5: base = f[`BSRBA_F_PARITY];
            3'h6: base = f[`BSRBA_F_SIGN] ^ f[`BSRBA_F_OVFL];
            default: base = f[`BSRBA_F_ZERO] | (f[`BSRBA_F_SIGN] ^ f[`BSRBA_F_OVFL]);
        endcase
        // odd codes test the negated condition
        cond_met = base ^ cc[0];
    endfunction

////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        bsrba_op_type op;
        bsrba_size_type sz;
        logic [31:0] mk, a, b, r, sv, wmk;
        logic [7:0] fl, lo_b, hi_b;
        logic [4:0] tb, idx;
        logic c, o, nb, left, upd, fire;
        logic [8:0] sum9;
        op = bsrba_op_type'(s_r.ctrl[`BSRBA_CTRL_OP]);
        sz = bsrba_size_type'(s_r.ctrl[`BSRBA_CTRL_SIZE]);
        mk = width_mask(sz);
        tb = top_bit(sz);
        a = s_r.dest & mk;
        b = s_r.src & mk;
        r = a;
        sv = b;
        fl = s_r.flags;
        c = s_r.flags[`BSRBA_F_CARRY];
        o = 1'b0;
        nb = 1'b0;
        left = 1'b0;
        upd = 1'b0;
        wmk = mk;
        idx = 5'h00;
        lo_b = s_r.dest[`BSRBA_LOW_F];
        hi_b = s_r.dest[`BSRBA_HIGH_F];
        sum9 = 9'h000;
        fire = 1'b0;
        s_nxt = s_r;

        // ---- datapath ----
        case (op)
            OP_AND: begin
                r = a & b;
                upd = 1'b1;
            end
            OP_OR: begin
                r = a | b;
                upd = 1'b1;
            end
            OP_XOR: begin
                r = a ^ b;
                upd = 1'b1;
            end
            OP_NOT: begin
                r = ~a & mk;
            end
            OP_SLL, OP_SRL, OP_SRA, OP_DSL, OP_DSR,
            OP_RTL, OP_RTR, OP_RTCL, OP_RTCR: begin
                left = (op == OP_SLL) || (op == OP_DSL) || (op == OP_RTL) || (op == OP_RTCL);
                // one bit per step; a count of zero leaves all untouched
                for (int i = 0; i < 31; i++) begin
                    if (5'(i) < s_r.count) begin
                        if (left) begin
                            o = r[tb];
                            case (op)
                                OP_RTL: nb = o;
                                OP_RTCL: nb = c;
                                OP_DSL: nb = sv[tb];
                                default: nb = 1'b0;
                            endcase
                            r = ((r << 1) | {31'h0, nb}) & mk;
                            sv = (sv << 1) & mk;
                        end else begin
                            o = r[0];
                            case (op)
                                OP_SRA: nb = r[tb];
                                OP_RTR: nb = o;
                                OP_RTCR: nb = c;
                                OP_DSR: nb = sv[0];
                                default: nb = 1'b0;
                            endcase
                            r = (r >> 1) | ({31'h0, nb} << tb);
                            sv = sv >> 1;
                        end
                        c = o;
                    end
                end
                fl[`BSRBA_F_CARRY] = c;
                // rotates touch only carry; shifts also refresh result flags
                upd = (s_r.count != 5'h00) && (op != OP_RTL) && (op != OP_RTR)
                    && (op != OP_RTCL) && (op != OP_RTCR);
            end
            OP_BTST, OP_BSET, OP_BCLR, OP_BINV: begin
                idx = s_r.count & tb;
                fl[`BSRBA_F_CARRY] = a[idx];
                case (op)
                    OP_BSET: r[idx] = 1'b1;
                    OP_BCLR: r[idx] = 1'b0;
                    OP_BINV: r[idx] = ~a[idx];
                    default: r = a;
                endcase
            end
            OP_SCUP: begin
                // descending walk so the lowest set bit is kept last
                for (int i = 31; i >= 0; i--) begin
                    if (b[i]) begin
                        r = 32'(i);
                    end
                end
                fl[`BSRBA_F_ZERO] = (b == 32'h0);
            end
            OP_SCDN: begin
                for (int i = 0; i < 32; i++) begin
                    if (b[i]) begin
                        r = 32'(i);
                    end
                end
                fl[`BSRBA_F_ZERO] = (b == 32'h0);
            end
            OP_SETC: begin
                wmk = `BSRBA_MASK_B;
                r = {31'h0, cond_met(s_r.ctrl[`BSRBA_CTRL_COND], s_r.flags)};
            end
            OP_PADD: begin
                wmk = `BSRBA_MASK_B;
                if ((lo_b & `BSRBA_NIB_MASK) > `BSRBA_NIB_MAX || s_r.flags[`BSRBA_F_AUX]) begin
                    sum9 = {1'b0, lo_b} + {1'b0, `BSRBA_ADJ_LO};
                    fl[`BSRBA_F_AUX] = 1'b1;
                end else begin
                    sum9 = {1'b0, lo_b};
                    fl[`BSRBA_F_AUX] = 1'b0;
                end
                if (lo_b > `BSRBA_PACK_MAX || s_r.flags[`BSRBA_F_CARRY]) begin
                    sum9[7:0] = sum9[7:0] + `BSRBA_ADJ_HI;
                    fl[`BSRBA_F_CARRY] = 1'b1;
                end else begin
                    fl[`BSRBA_F_CARRY] = 1'b0;
                end
                r = {24'h0, sum9[7:0]};
                upd = 1'b1;
            end
            OP_PSUB: begin
                wmk = `BSRBA_MASK_B;
                if ((lo_b & `BSRBA_NIB_MASK) > `BSRBA_NIB_MAX || s_r.flags[`BSRBA_F_AUX]) begin
                    sum9 = {1'b0, lo_b} - {1'b0, `BSRBA_ADJ_LO};
                    fl[`BSRBA_F_AUX] = 1'b1;
                end else begin
                    sum9 = {1'b0, lo_b};
                    fl[`BSRBA_F_AUX] = 1'b0;
                end
                if (lo_b > `BSRBA_PACK_MAX || s_r.flags[`BSRBA_F_CARRY]) begin
                    sum9[7:0] = sum9[7:0] - `BSRBA_ADJ_HI;
                    fl[`BSRBA_F_CARRY] = 1'b1;
                end else begin
                    fl[`BSRBA_F_CARRY] = 1'b0;
                end
                r = {24'h0, sum9[7:0]};
                upd = 1'b1;
            end
            OP_UADD, OP_USUB: begin
                wmk = `BSRBA_MASK_W;
                if ((lo_b & `BSRBA_NIB_MASK) > `BSRBA_NIB_MAX || s_r.flags[`BSRBA_F_AUX]) begin
                    if (op == OP_UADD) begin
                        lo_b = lo_b + `BSRBA_ADJ_LO;
                        hi_b = hi_b + 8'h01;
                    end else begin
                        lo_b = lo_b - `BSRBA_ADJ_LO;
                        hi_b = hi_b - 8'h01;
                    end
                    fl[`BSRBA_F_CARRY] = 1'b1;
                    fl[`BSRBA_F_AUX] = 1'b1;
                end else begin
                    fl[`BSRBA_F_CARRY] = 1'b0;
                    fl[`BSRBA_F_AUX] = 1'b0;
                end
                r = {16'h0, hi_b, lo_b & `BSRBA_NIB_MASK};
            end
            OP_UMUL: begin
                wmk = `BSRBA_MASK_W;
                r = {16'h0, lo_b / `BSRBA_DEC_BASE, lo_b % `BSRBA_DEC_BASE};
                upd = 1'b1;
            end
            OP_UDIV: begin
                wmk = `BSRBA_MASK_W;
                // high byte cleared so a following divide sees one byte
                r = {16'h0, 8'h00, 8'(hi_b * `BSRBA_DEC_BASE + lo_b)};
                upd = 1'b1;
            end
            default: begin
                r = a;
            end
        endcase
        if (upd) begin
            fl[`BSRBA_F_ZERO] = ((r & wmk) == 32'h0);
            fl[`BSRBA_F_SIGN] = (wmk == `BSRBA_MASK_B) ? r[7] : r[tb];
            fl[`BSRBA_F_PARITY] = ~^r[7:0];
        end
        if (op == OP_AND || op == OP_OR || op == OP_XOR) begin
            fl[`BSRBA_F_CARRY] = 1'b0;
            fl[`BSRBA_F_OVFL] = 1'b0;
        end

        // ---- sequencing ----
        case (s_r.state)
            ST_IDLE: begin
            end
            ST_EXEC: begin
                // bit test, and a scan of a zero source, leave the operand untouched
                if (op != OP_BTST && !((op == OP_SCUP || op == OP_SCDN) && b == 32'h0)) begin
                    s_nxt.dest = (s_r.dest & ~wmk) | (r & wmk);
                end
                s_nxt.src_zero = (b == 32'h0);
                s_nxt.flags = fl;
                s_nxt.state = ST_IDLE;
            end
            default: begin
                s_nxt.state = ST_IDLE;
            end
        endcase

        // ---- axi4-lite write ----
        // writes are held off while an operation runs, so no register has two writers
        if (axi_req.awvalid && axi_rsp.awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = axi_req.wdata;
            s_nxt.w_strb = axi_req.wstrb;
        end
        if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `BSRBA_RESP_OKAY;
            case ({s_r.aw_addr[7:2], 2'b00})
                `BSRBA_OFS_CTRL: begin
                    s_nxt.ctrl = merge(s_r.ctrl, s_r.w_data, s_r.w_strb);
                    fire = s_r.w_strb[3] && s_r.w_data[`BSRBA_CTRL_GO];
                    s_nxt.ctrl[`BSRBA_CTRL_GO] = 1'b0;
                end
                `BSRBA_OFS_DEST: s_nxt.dest = merge(s_r.dest, s_r.w_data, s_r.w_strb);
                `BSRBA_OFS_SRC: s_nxt.src = merge(s_r.src, s_r.w_data, s_r.w_strb);
                `BSRBA_OFS_COUNT: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.count = s_r.w_data[`BSRBA_COUNT_F];
                    end
                end
                `BSRBA_OFS_FLAGS: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.flags = s_r.w_data[7:0];
                    end
                end
                `BSRBA_OFS_STATUS: begin
                end
                default: s_nxt.bresp = `BSRBA_RESP_SLVERR;
            endcase
            if (fire) begin
                s_nxt.state = ST_EXEC;
            end
        end
        if (s_r.bvalid && axi_req.bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // ---- axi4-lite read ----
        if (axi_req.arvalid && axi_rsp.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = `BSRBA_RESP_OKAY;
            case ({axi_req.araddr[7:2], 2'b00})
                `BSRBA_OFS_CTRL: s_nxt.rdata = s_r.ctrl;
                `BSRBA_OFS_DEST: s_nxt.rdata = s_r.dest;
                `BSRBA_OFS_SRC: s_nxt.rdata = s_r.src;
                `BSRBA_OFS_COUNT: s_nxt.rdata = {27'h0, s_r.count};
                `BSRBA_OFS_FLAGS: s_nxt.rdata = {24'h0, s_r.flags};
                `BSRBA_OFS_STATUS: begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rdata[`BSRBA_ST_BUSY] = (s_r.state != ST_IDLE);
                    s_nxt.rdata[`BSRBA_ST_SRCZ] = s_r.src_zero;
                end
                default: begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rresp = `BSRBA_RESP_SLVERR;
                end
            endcase
        end else if (s_r.rvalid && axi_req.rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        axi_rsp.awready = !s_r.aw_held && !s_r.bvalid && (s_r.state == ST_IDLE);
        axi_rsp.wready = !s_r.w_held && !s_r.bvalid && (s_r.state == ST_IDLE);
        axi_rsp.bvalid = s_r.bvalid;
        axi_rsp.bresp = s_r.bresp;
        axi_rsp.arready = !s_r.rvalid;
        axi_rsp.rvalid = s_r.rvalid;
        axi_rsp.rdata = s_r.rdata;
        axi_rsp.rresp = s_r.rresp;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '{state: ST_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule
`default_nettype wire

/* File: bench/bsrba_checker.sv */
// Purpose: bus timing checks of the bcd/shift/bit datapath
// Assumes: sees bsrba_core ports only, one clock domain
// Notes: bind statement at the foot
`timescale 1ns/100ps
`default_nettype none
module bsrba_checker
    import bsrba_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire bsrba_axi_req_type axi_req,
    input wire bsrba_axi_rsp_type axi_rsp
);
////////////////////////////////////////////////////////////
default clocking dc @(posedge aclk);
endclocking
default disable iff (!aresetn);
sequence both_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
endsequence
sequence rd_taken;
    axi_req.arvalid && axi_rsp.arready;
endsequence
a_write_answer: assert property (both_taken |=> ##1 axi_rsp.bvalid)
    else $error("write answer not two cycles after take");
a_read_answer: assert property (rd_taken |=> axi_rsp.rvalid)
    else $error("read answer not one cycle after take");
a_b_release: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write answer kept after handshake");
a_r_release: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
    else $error("read answer kept after handshake");
a_write_refused: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while answer pending");
a_read_refused: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while answer pending");
a_unmapped_read: assert property (rd_taken ##0 (axi_req.araddr[7:2] > 6'h05)
    |=> axi_rsp.rresp == 2'b10 && axi_rsp.rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
a_mapped_read: assert property (rd_taken ##0 (axi_req.araddr[7:2] <= 6'h05)
    |=> axi_rsp.rresp == 2'b00)
    else $error("mapped read refused");
a_go_reads_zero: assert property (rd_taken ##0 (axi_req.araddr[7:2] == 6'h00)
    |=> !axi_rsp.rdata[31])
    else $error("go bit read back as one");
endmodule
bind bsrba_core bsrba_checker u_bsrba_checker (.aclk(aclk), .aresetn(aresetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp));
`default_nettype wire

/* File: bench/bsrba_host.sv */
// Purpose: decoder-side master feeding operands over axi4-lite
// Assumes: bsrba_pkg types, one clock
// Notes: stuck rises when a wait runs out
`timescale 1ns/100ps
`default_nettype none
module bsrba_host
    import bsrba_pkg::*;
(
    input wire logic aclk,
    input wire bsrba_axi_rsp_type axi_rsp,
    output var bsrba_axi_req_type axi_req,
    output var logic stuck
);
////////////////////////////////////////////////////////////
initial begin
    axi_req = '0;
    stuck = 1'b0;
end
// released payload flips so a late sample of it shows
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
        @(posedge aclk);
        if (axi_req.awvalid && axi_rsp.awready) begin
            axi_req.awvalid <= 1'b0;
            axi_req.awaddr <= ~a;
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            axi_req.wvalid <= 1'b0;
            axi_req.wdata <= ~d;
        end
        if (axi_rsp.bvalid) break;
    end
    axi_req.bready <= 1'b0;
    if (n == 64) stuck <= 1'b1;
endtask
task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
        @(posedge aclk);
        if (axi_req.arvalid && axi_rsp.arready) begin
            axi_req.arvalid <= 1'b0;
            axi_req.araddr <= ~a;
        end
        if (axi_rsp.rvalid) break;
    end
    axi_req.rready <= 1'b0;
    if (n == 64) stuck <= 1'b1;
endtask
endmodule
`default_nettype wire

/* File: bench/tb_bcd_shift_rotate_bit_alu.sv */
// Purpose: self-checking bench of the bcd/shift/bit datapath
// Assumes: bsrba_host as master, bsrba_checker bound to the core
// Notes: expected values hand-worked per operation, checked on read
`include "bsrba_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_bcd_shift_rotate_bit_alu import bsrba_pkg::*;;
logic aclk;
logic aresetn;
bsrba_axi_req_type axi_req;
bsrba_axi_rsp_type axi_rsp;
logic stuck;
logic [3:0] cc_sel;
int num_errors = 0;
int comparisons = 0;
logic [33:0] exp_q[$];
logic [33:0] msk_q[$];
localparam logic [33:0] ALL_BITS = 34'h3_ffff_ffff;
////////////////////////////////////////////////////////////
bsrba_core u_bsrba_core (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp));
bsrba_host u_bsrba_host (.aclk(aclk), .axi_rsp(axi_rsp), .axi_req(axi_req), .stuck(stuck));
initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
end
task automatic finish_test();
    if (num_errors == 0 && comparisons > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
endtask
task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp, input logic [33:0] msk);
    comparisons++;
    if ((got & msk) !== (exp & msk)) begin
        num_errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
// oldest note pairs with each read answer
always @(posedge aclk) begin
    if (aresetn && axi_rsp.rvalid && axi_req.rready) begin
        cmp_rd({axi_rsp.rresp, axi_rsp.rdata}, exp_q.pop_front(), msk_q.pop_front());
    end
    if (stuck) begin
        num_errors++;
        finish_test();
    end
end
////////////////////////////////////////////////////////////
task automatic expect_rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    u_bsrba_host.rd(a);
endtask
// entries msb first: zero|(sign^ovfl), sign^ovfl, parity, sign, carry|zero, zero, carry, ovfl
function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] f);
    logic [7:0] t;
    t = {f[3] | (f[4] ^ f[5]), f[4] ^ f[5], f[1], f[4], f[0] | f[3], f[3], f[0], f[5]};
    return t[cc[3:1]] ^ cc[0];
endfunction
task automatic run(input logic [4:0] op, input logic [1:0] sz, input logic [31:0] d,
        input logic [31:0] s, input logic [4:0] c, input logic [7:0] f,
        input logic [31:0] ed, input logic [7:0] ef, input logic [7:0] mf);
    logic [31:0] md;
    md = (sz == 2'h0) ? `BSRBA_MASK_B : (sz == 2'h1) ? `BSRBA_MASK_W : `BSRBA_MASK_D;
    u_bsrba_host.wr(`BSRBA_OFS_SRC, s);
    u_bsrba_host.wr(`BSRBA_OFS_DEST, d);
    u_bsrba_host.wr(`BSRBA_OFS_COUNT, {27'h0, c});
    u_bsrba_host.wr(`BSRBA_OFS_FLAGS, {24'h0, f});
    u_bsrba_host.wr(`BSRBA_OFS_CTRL, {1'b1, 15'h0, cc_sel, 2'h0, sz, 3'h0, op});
    expect_rd(`BSRBA_OFS_DEST, {2'b00, ed}, {2'b11, md});
    expect_rd(`BSRBA_OFS_FLAGS, {26'h0, ef}, {26'h3ff_ffff, mf});
endtask
initial begin
    int i;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] e;
    logic [7:0] f;
    aresetn = 1'b0;
    cc_sel = 4'h0;
    void'($urandom(32'h88aff7b2));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    expect_rd(`BSRBA_OFS_DEST, 34'h0, ALL_BITS);
    expect_rd(8'h18, {2'b10, 32'h0}, ALL_BITS);
    run(5'h14, 2'h0, 32'h9a, 32'h0, 5'h0, 8'h00, 32'h00, 8'h01, 8'h01);
    run(5'h15, 2'h0, 32'hff, 32'h0, 5'h0, 8'h05, 32'h99, 8'h01, 8'h01);
    run(5'h16, 2'h1, 32'h000f, 32'h0, 5'h0, 8'h00, 32'h0105, 8'h01, 8'h01);
    run(5'h17, 2'h1, 32'h01fd, 32'h0, 5'h0, 8'h04, 32'h0007, 8'h01, 8'h01);
    run(5'h18, 2'h1, 32'h003f, 32'h0, 5'h0, 8'h00, 32'h0603, 8'h00, 8'h00);
    run(5'h19, 2'h1, 32'h0407, 32'h0, 5'h0, 8'h00, 32'h002f, 8'h00, 8'h00);
    for (i = 0; i < 4; i++) begin
        a = $urandom;
        b = $urandom;
        e = (i == 0) ? a & b : (i == 1) ? a | b : (i == 2) ? a ^ b : ~a;
        run(i[4:0], 2'h2, a, b, 5'h0, 8'h01, e, {7'h0, i == 3}, 8'h01);
    end
    run(5'h04, 2'h2, 32'h3, 32'h0, 5'h1f, 8'h00, 32'h8000_0000, 8'h01, 8'h01);
    run(5'h04, 2'h0, 32'ha5, 32'h0, 5'h03, 8'h00, 32'h28, 8'h01, 8'h01);
    run(5'h05, 2'h2, 32'h8000_0018, 32'h0, 5'h04, 8'h00, 32'h0800_0001, 8'h01, 8'h01);
    run(5'h06, 2'h2, 32'h8000_0000, 32'h0, 5'h1f, 8'h01, 32'hffff_ffff, 8'h00, 8'h01);
    run(5'h06, 2'h1, 32'h8008, 32'h0, 5'h04, 8'h00, 32'hf800, 8'h01, 8'h01);
    // both operands dword, one size field serves both
    run(5'h07, 2'h2, 32'h1334_5678, 32'habcd_ef01, 5'h08, 8'h00, 32'h3456_78ab, 8'h01, 8'h01);
    expect_rd(`BSRBA_OFS_SRC, {2'b00, 32'habcd_ef01}, ALL_BITS);
    run(5'h08, 2'h2, 32'h1234_56f8, 32'habcd_ef01, 5'h08, 8'h00, 32'h0112_3456, 8'h01, 8'h01);
    run(5'h09, 2'h2, 32'h8123_4567, 32'h0, 5'h04, 8'h01, 32'h1234_5678, 8'h00, 8'h01);
    run(5'h09, 2'h0, 32'h81, 32'h0, 5'h09, 8'h00, 32'h03, 8'h01, 8'h01);
    run(5'h0a, 2'h2, 32'h8000_0001, 32'h0, 5'h1f, 8'h01, 32'h3, 8'h00, 8'h01);
    run(5'h0b, 2'h0, 32'h40, 32'h0, 5'h01, 8'h01, 32'h81, 8'h00, 8'h01);
    run(5'h0c, 2'h2, 32'h2, 32'h0, 5'h01, 8'h01, 32'h8000_0001, 8'h00, 8'h01);
    run(5'h0d, 2'h2, 32'h20, 32'h0, 5'h05, 8'h00, 32'h20, 8'h01, 8'h01);
    run(5'h0e, 2'h2, 32'h0, 32'h0, 5'h1f, 8'h01, 32'h8000_0000, 8'h00, 8'h01);
    run(5'h0f, 2'h2, 32'hffff_ffff, 32'h0, 5'h00, 8'h00, 32'hffff_fffe, 8'h01, 8'h01);
    run(5'h10, 2'h2, 32'h10, 32'h0, 5'h04, 8'h00, 32'h0, 8'h01, 8'h01);
    run(5'h11, 2'h2, 32'h55, 32'h0001_0100, 5'h0, 8'h00, 32'h08, 8'h00, 8'h08);
    run(5'h12, 2'h2, 32'h55, 32'h0001_0100, 5'h0, 8'h00, 32'h10, 8'h00, 8'h08);
    run(5'h11, 2'h2, 32'h55, 32'h0, 5'h0, 8'h00, 32'h55, 8'h08, 8'h08);
    // idle with last source zero; command kept, go reads back clear
    expect_rd(`BSRBA_OFS_STATUS, {2'b00, 32'h0000_0002}, ALL_BITS);
    expect_rd(`BSRBA_OFS_CTRL, {2'b00, 32'h0000_0211}, ALL_BITS);
    for (i = 0; i < 16; i++) begin
        cc_sel = i[3:0];
        a = $urandom;
        f = 8'($urandom);
        run(5'h13, 2'h2, a, 32'h0, 5'h0, f, {a[31:8], 7'h0, cond_true(i[3:0], f)}, f, 8'h00);
    end
    repeat (4) @(posedge aclk);
    finish_test();
end
endmodule
`default_nettype wire
